// File: lsdaa_pkg.sv
/*
 * lsdaa_pkg: shared constants for the line-side access register bank.
 * assumes: 8-bit registers on a 6-bit index address, one clock domain.
 */
package lsdaa_pkg;
	// register indices
	localparam logic [5:0] ADDR_MAIN_CTRL = 6'h01;
	localparam logic [5:0] ADDR_HOOK_CTRL = 6'h05;
	localparam logic [5:0] ADDR_DEV_STATUS = 6'h0c;
	localparam logic [5:0] ADDR_DEV_REV = 6'h0d;
	localparam logic [5:0] ADDR_RSVD_14 = 6'h0e;
	localparam logic [5:0] ADDR_PATH_GAIN = 6'h0f;
	localparam logic [5:0] ADDR_LIF_A = 6'h10;
	localparam logic [5:0] ADDR_LIF_B = 6'h11;
	localparam logic [5:0] ADDR_LIF_C = 6'h12;
	localparam logic [5:0] ADDR_FAULT = 6'h13;
	localparam logic [5:0] ADDR_MON_RX = 6'h14;
	localparam logic [5:0] ADDR_MON_TX = 6'h15;
	localparam logic [5:0] ADDR_RING_A = 6'h16;
	localparam logic [5:0] ADDR_RING_B = 6'h17;
	localparam logic [5:0] ADDR_RING_C = 6'h18;
	localparam logic [5:0] ADDR_RCAL = 6'h19;
	localparam logic [5:0] ADDR_DCTERM = 6'h1a;
	localparam logic [5:0] ADDR_LOOP_I = 6'h1c;
	localparam logic [5:0] ADDR_LINE_V = 6'h1d;
	localparam logic [5:0] ADDR_HOOK_X = 6'h1f;
	localparam logic [5:0] ADDR_THR_LVL = 6'h2b;
	localparam logic [5:0] ADDR_THR_CTL = 6'h2c;
	localparam logic [5:0] ADDR_SPARK = 6'h3b;
	// main control field positions
	localparam int BIT_SOFT_RESET = 7;
	localparam int BIT_PWM_HI = 5;
	localparam int BIT_PWM_LO = 4;
	localparam int BIT_LOOPBACK = 1;
	localparam logic [7:0] MAIN_CTRL_WMASK = 8'hb2;
	// hook control field position
	localparam int BIT_HOOK = 0;
	// path gain field positions
	localparam int BIT_TX_MUTE = 7;
	localparam int BIT_TX_ATT_HI = 6;
	localparam int BIT_TX_ATT_LO = 4;
	localparam int BIT_RX_MUTE = 3;
	localparam int BIT_RX_GAIN_HI = 2;
	// values after reset
	localparam logic [7:0] RST_REG = 8'h00;
	localparam logic [7:0] RST_REV = 8'h00;
endpackage

// File: lsdaa_cfg_if.sv
/*
 * lsdaa_cfg_if: control fields carried from the register file to the datapath.
 * assumes: one clock, fields are register outputs.
 */
`timescale 1ns/1ps
interface lsdaa_cfg_if;
	logic loopback; // digital loopback enable
	logic tx_mute; // transmit mute
	logic [2:0] tx_att; // transmit attenuation select
	logic rx_mute; // receive mute
	logic [2:0] rx_gain; // receive gain select
	modport src (output loopback, tx_mute, tx_att, rx_mute, rx_gain);
	modport dst (input loopback, tx_mute, tx_att, rx_mute, rx_gain);
endinterface

// File: lsdaa_path.sv
/*
 * lsdaa_path: sample path with transmit and receive filter stages and the
 * isolation loopback selector.
 * assumes: samples arrive with a one-cycle valid, cfg fields are registered.
 */
`timescale 1ns/1ps
module lsdaa_path import lsdaa_pkg::*; #(
	parameter int W = 16
) (
	input wire logic i_clk,
	input wire logic i_resetn,
	lsdaa_cfg_if.dst cfg,
	input wire logic i_tx_valid,
	input wire logic [W-1:0] i_tx_data,
	input wire logic i_line_valid,
	input wire logic [W-1:0] i_line_data,
	output logic o_rx_valid,
	output logic [W-1:0] o_rx_data,
	output logic o_line_valid,
	output logic [W-1:0] o_line_data
);
	// scale by 3-bit step: right shift per step
	function automatic logic [W-1:0] scale(input logic [W-1:0] d, input logic mute,
		input logic [2:0] s);
		scale = mute ? '0 : (d >> s);
	endfunction

	logic tx_v_q; // transmit filter stage valid
	logic [W-1:0] tx_f_q; // transmit filter output
	logic rx_v_q; // receive filter stage valid
	logic [W-1:0] rx_f_q; // receive filter output
	logic rx_in_v; // receive filter input valid
	logic [W-1:0] rx_in; // receive filter input

	// transmit filter stage
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			tx_v_q <= 1'b0;
			tx_f_q <= '0;
		end else begin
			tx_v_q <= i_tx_valid;
			if (i_tx_valid) begin
				tx_f_q <= scale(i_tx_data, cfg.tx_mute, cfg.tx_att);
			end
		end
	end

	// loopback feeds transmit filter output into receive filter
	always_comb begin
		rx_in_v = cfg.loopback ? tx_v_q : i_line_valid;
		rx_in = cfg.loopback ? tx_f_q : i_line_data;
	end

	// receive filter stage
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rx_v_q <= 1'b0;
			rx_f_q <= '0;
		end else begin
			rx_v_q <= rx_in_v;
			if (rx_in_v) begin
				// all three gain bits count; codes above four saturate at top gain
				rx_f_q <= cfg.rx_mute ? '0 :
					(rx_in >> ((cfg.rx_gain > 3'h4) ? 3'h0 : (3'h4 - cfg.rx_gain)));
			end
		end
	end

	// line output silenced during loopback
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_line_valid <= 1'b0;
			o_line_data <= '0;
		end else begin
			o_line_valid <= tx_v_q && !cfg.loopback;
			o_line_data <= tx_f_q;
		end
	end

	assign o_rx_valid = rx_v_q;
	assign o_rx_data = rx_f_q;

	// looped sample reaches receive output two cycles after entry
	loop_path_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(i_tx_valid ##1 cfg.loopback) |=> o_rx_valid)
		else $error("looped sample missed receive output");
endmodule

// File: lsdaa_regs.sv
/*
 * lsdaa_regs: register bank of the line-side access device with software
 * reset, pwm mode, hook state, gain control and isolation loopback.
 * assumes: plain register port, read data valid the cycle after the strobe,
 * status inputs come from pins and are synchronised here.
 */
// What this block does
// - Soft reset bit returns all writable registers
// - Soft reset bit clears itself, reads zero
// - Loopback bit loops data across barrier
// - Looped data passes transmit and receive filters
// - Two-bit field selects pwm output mode
// - Gain register: mutes, attenuation, receive gain
// - Hook bit sets off-hook, clear on-hook
`timescale 1ns/1ps
module lsdaa_regs import lsdaa_pkg::*; #(
	parameter int W = 16,
	parameter logic [7:0] REVISION = RST_REV // arbitrary value
) (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic [5:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic [7:0] i_dev_status,
	input wire logic [7:0] i_loop_current,
	input wire logic [7:0] i_line_voltage,
	input wire logic i_tx_valid,
	input wire logic [W-1:0] i_tx_data,
	input wire logic i_line_valid,
	input wire logic [W-1:0] i_line_data,
	output logic o_rx_valid,
	output logic [W-1:0] o_rx_data,
	output logic o_line_valid,
	output logic [W-1:0] o_line_data,
	output logic o_off_hook,
	output logic [1:0] o_pulse_width_mode_select
);
	// one aligned write decode used for the control, hook and gain registers
	function automatic logic hit(input logic [5:0] a, input logic [5:0] r);
		hit = (a == r);
	endfunction

	lsdaa_cfg_if cfg_bus (); // fields handed to the datapath

	logic soft_reset_trigger_q; // pending soft reset, lasts one cycle
	logic [1:0] pulse_width_mode_select_q; // pwm mode
	logic isolation_loopback_enable_q; // loopback enable
	logic hook_state_control_q; // off-hook when set
	logic [7:0] path_gain_q; // mutes, attenuation, gain
	logic [7:0] rw_q [0:15]; // plain read/write registers
	logic [3:0] rw_idx; // rw array slot of the address
	logic rw_hit; // address names a plain rw register
	logic [7:0] st_s1_q [0:2]; // status sync stage 1
	logic [7:0] st_s2_q [0:2]; // status sync stage 2
	logic [7:0] st_s3_q [0:2]; // status sync stage 3
	logic [7:0] st_q [0:2]; // accepted status value
	logic [7:0] rdata_d; // read mux
	logic clr; // soft reset in progress

	assign clr = soft_reset_trigger_q;

	// map writable plain registers onto array slots
	always_comb begin
		rw_hit = 1'b1;
		rw_idx = 4'h0;
		case (i_addr)
			ADDR_LIF_A: rw_idx = 4'h0;
			ADDR_LIF_B: rw_idx = 4'h1;
			ADDR_LIF_C: rw_idx = 4'h2;
			ADDR_FAULT: rw_idx = 4'h3;
			ADDR_MON_RX: rw_idx = 4'h4;
			ADDR_MON_TX: rw_idx = 4'h5;
			ADDR_RING_A: rw_idx = 4'h6;
			ADDR_RING_B: rw_idx = 4'h7;
			ADDR_RING_C: rw_idx = 4'h8;
			ADDR_RCAL: rw_idx = 4'h9;
			ADDR_DCTERM: rw_idx = 4'ha;
			ADDR_HOOK_X: rw_idx = 4'hb;
			ADDR_THR_LVL: rw_idx = 4'hc;
			ADDR_THR_CTL: rw_idx = 4'hd;
			ADDR_SPARK: rw_idx = 4'he;
			default: rw_hit = 1'b0;
		endcase
	end

	// soft reset strobe: set by write, drops next cycle
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			soft_reset_trigger_q <= 1'b0;
		end else begin
			soft_reset_trigger_q <= i_wr && hit(i_addr, ADDR_MAIN_CTRL)
				&& i_wdata[BIT_SOFT_RESET] && !soft_reset_trigger_q;
		end
	end

	// main control fields
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			pulse_width_mode_select_q <= 2'h0;
			isolation_loopback_enable_q <= 1'b0;
		end else if (clr) begin
			pulse_width_mode_select_q <= 2'h0;
			isolation_loopback_enable_q <= 1'b0;
		end else if (i_wr && hit(i_addr, ADDR_MAIN_CTRL) && !i_wdata[BIT_SOFT_RESET]) begin
			pulse_width_mode_select_q <= i_wdata[BIT_PWM_HI:BIT_PWM_LO];
			// host must already be off-hook; not enforced here
			isolation_loopback_enable_q <= i_wdata[BIT_LOOPBACK];
		end
	end

	// hook state
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			hook_state_control_q <= 1'b0;
		end else if (clr) begin
			hook_state_control_q <= 1'b0;
		end else if (i_wr && hit(i_addr, ADDR_HOOK_CTRL)) begin
			hook_state_control_q <= i_wdata[BIT_HOOK];
		end
	end

	// path gain
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			path_gain_q <= RST_REG;
		end else if (clr) begin
			path_gain_q <= RST_REG;
		end else if (i_wr && hit(i_addr, ADDR_PATH_GAIN)) begin
			path_gain_q <= i_wdata;
		end
	end

	// plain read/write registers
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			for (int k = 0; k < 16; k++) begin
				rw_q[k] <= RST_REG;
			end
		end else if (clr) begin
			for (int k = 0; k < 16; k++) begin
				rw_q[k] <= RST_REG;
			end
		end else if (i_wr && rw_hit) begin
			rw_q[rw_idx] <= i_wdata;
		end
	end

	// status pins: three flops, accept when stages two and three agree
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			for (int k = 0; k < 3; k++) begin
				st_s1_q[k] <= RST_REG;
				st_s2_q[k] <= RST_REG;
				st_s3_q[k] <= RST_REG;
				st_q[k] <= RST_REG;
			end
		end else begin
			st_s1_q[0] <= i_dev_status;
			st_s1_q[1] <= i_loop_current;
			st_s1_q[2] <= i_line_voltage;
			for (int k = 0; k < 3; k++) begin
				st_s2_q[k] <= st_s1_q[k];
				st_s3_q[k] <= st_s2_q[k];
				if (st_s2_q[k] == st_s3_q[k]) begin
					st_q[k] <= st_s3_q[k];
				end
			end
		end
	end

	// read mux
	always_comb begin
		rdata_d = 8'h00;
		case (i_addr)
			ADDR_MAIN_CTRL: rdata_d = {2'h0, pulse_width_mode_select_q, 2'h0,
				isolation_loopback_enable_q, 1'b0};
			ADDR_HOOK_CTRL: rdata_d = {7'h00, hook_state_control_q};
			ADDR_DEV_STATUS: rdata_d = st_q[0];
			ADDR_DEV_REV: rdata_d = REVISION;
			ADDR_PATH_GAIN: rdata_d = path_gain_q;
			ADDR_LOOP_I: rdata_d = st_q[1];
			ADDR_LINE_V: rdata_d = st_q[2];
			default: rdata_d = rw_hit ? rw_q[rw_idx] : 8'h00;
		endcase
	end

	// read data registered, valid cycle after strobe
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_rdata <= 8'h00;
		end else if (i_rd) begin
			o_rdata <= rdata_d;
		end
	end

	// pin outputs
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_off_hook <= 1'b0;
			o_pulse_width_mode_select <= 2'h0;
		end else begin
			o_off_hook <= hook_state_control_q;
			o_pulse_width_mode_select <= pulse_width_mode_select_q;
		end
	end

	// gain and loopback fields to datapath
	assign cfg_bus.loopback = isolation_loopback_enable_q;
	assign cfg_bus.tx_mute = path_gain_q[BIT_TX_MUTE];
	assign cfg_bus.tx_att = path_gain_q[BIT_TX_ATT_HI:BIT_TX_ATT_LO];
	assign cfg_bus.rx_mute = path_gain_q[BIT_RX_MUTE];
	assign cfg_bus.rx_gain = path_gain_q[BIT_RX_GAIN_HI:0];

	// filter path with loopback
	lsdaa_path #(.W(W)) u_path (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.cfg(cfg_bus.dst),
		.i_tx_valid(i_tx_valid),
		.i_tx_data(i_tx_data),
		.i_line_valid(i_line_valid),
		.i_line_data(i_line_data),
		.o_rx_valid(o_rx_valid),
		.o_rx_data(o_rx_data),
		.o_line_valid(o_line_valid),
		.o_line_data(o_line_data)
	);

	// soft reset write clears gain and hook registers two cycles later
	sr_clears_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(i_wr && i_addr == ADDR_MAIN_CTRL && i_wdata[7] && !soft_reset_trigger_q)
		|-> ##2 (path_gain_q == 8'h00 && !hook_state_control_q))
		else $error("soft reset left a register set");

	// soft reset strobe never lasts two cycles
	sr_selfclear_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		soft_reset_trigger_q |=> !soft_reset_trigger_q)
		else $error("soft reset did not clear itself");

	// reserved bits of main control read zero
	main_rsvd_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(i_rd && i_addr == ADDR_MAIN_CTRL) |=> ((o_rdata & ~MAIN_CTRL_WMASK) == 8'h00))
		else $error("reserved control bit read nonzero");

	// loopback bit follows a write
	loop_bit_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(i_wr && i_addr == ADDR_MAIN_CTRL && !i_wdata[7] && !soft_reset_trigger_q)
		|=> (isolation_loopback_enable_q == $past(i_wdata[1])))
		else $error("loopback bit not taken");

	// pwm mode reaches pin two cycles after write
	pwm_mode_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(i_wr && i_addr == ADDR_MAIN_CTRL && !i_wdata[7] && !soft_reset_trigger_q)
		|-> ##2 (o_pulse_width_mode_select == $past(i_wdata[5:4], 2)))
		else $error("pwm mode not on pin");

	// hook bit reaches off-hook pin two cycles after write
	hook_pin_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(i_wr && i_addr == ADDR_HOOK_CTRL && !soft_reset_trigger_q)
		|-> ##2 (o_off_hook == $past(i_wdata[0], 2)))
		else $error("hook pin wrong");

	// gain register read back matches write
	gain_rb_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(i_wr && i_addr == ADDR_PATH_GAIN && !soft_reset_trigger_q)
		##1 (i_rd && i_addr == ADDR_PATH_GAIN && !soft_reset_trigger_q)
		|=> (o_rdata == $past(i_wdata, 2)))
		else $error("gain register readback wrong");

	// line output quiet while looping
	loop_quiet_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(isolation_loopback_enable_q && $past(isolation_loopback_enable_q)) |=> !o_line_valid)
		else $error("line driven during loopback");

	// soft reset strobe wins over any write in its cycle
	sr_prio_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		soft_reset_trigger_q |=> (path_gain_q == RST_REG && !hook_state_control_q
		&& pulse_width_mode_select_q == 2'h0 && !isolation_loopback_enable_q))
		else $error("soft reset lost to a write");

	// soft reset also empties the plain registers
	sr_rw_clear_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		soft_reset_trigger_q |=> (rw_q[0] == RST_REG && rw_q[14] == RST_REG))
		else $error("plain register kept after soft reset");

	// other fields of a soft reset write are ignored
	sr_ignore_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(i_wr && i_addr == ADDR_MAIN_CTRL && i_wdata[7] && !soft_reset_trigger_q)
		|=> ($stable(pulse_width_mode_select_q) && $stable(isolation_loopback_enable_q)))
		else $error("soft reset write changed a field");

	// soft reset bit always reads zero
	sr_read_zero_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(i_rd && i_addr == ADDR_MAIN_CTRL) |=> !o_rdata[BIT_SOFT_RESET])
		else $error("soft reset bit read as one");

	// hook bit takes the written value
	hook_bit_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(i_wr && i_addr == ADDR_HOOK_CTRL && !soft_reset_trigger_q)
		|=> (hook_state_control_q == $past(i_wdata[BIT_HOOK])))
		else $error("hook bit not taken");

	// hook register reads the hook bit only
	hook_read_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(i_rd && i_addr == ADDR_HOOK_CTRL)
		|=> (o_rdata == {7'h00, $past(hook_state_control_q)}))
		else $error("hook register read wrong");

	// pwm field takes the written value
	pwm_field_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(i_wr && i_addr == ADDR_MAIN_CTRL && !i_wdata[7] && !soft_reset_trigger_q)
		|=> (pulse_width_mode_select_q == $past(i_wdata[5:4])))
		else $error("pwm field not taken");

	// pwm field reads back in place
	pwm_read_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(i_rd && i_addr == ADDR_MAIN_CTRL)
		|=> (o_rdata[5:4] == $past(pulse_width_mode_select_q)))
		else $error("pwm field read wrong");

	// loopback bit reads back in place
	loop_read_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(i_rd && i_addr == ADDR_MAIN_CTRL)
		|=> (o_rdata[1] == $past(isolation_loopback_enable_q)))
		else $error("loopback bit read wrong");

	// gain register takes the whole written byte
	gain_write_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(i_wr && i_addr == ADDR_PATH_GAIN && !soft_reset_trigger_q)
		|=> (path_gain_q == $past(i_wdata)))
		else $error("gain register not taken");

	// gain register read shows the stored byte
	gain_read_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(i_rd && i_addr == ADDR_PATH_GAIN) |=> (o_rdata == $past(path_gain_q)))
		else $error("gain register read wrong");

	// muted transmit sample reaches the line as zero
	tx_mute_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(i_tx_valid && path_gain_q[BIT_TX_MUTE]) |-> ##2 (o_line_data == '0))
		else $error("transmit mute leaked");

	// muted receive sample leaves the filter as zero
	rx_mute_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(i_line_valid && !isolation_loopback_enable_q && path_gain_q[BIT_RX_MUTE])
		|=> (o_rx_data == '0))
		else $error("receive mute leaked");
endmodule

// File: lsdaa_far_model.sv
/*
 * lsdaa_far_model: far side of the sample path, hands line samples to the
 * block on request.
 * assumes: one clock, the bench asks for a sample with a one-cycle i_send.
 */
`timescale 1ns/1ps
module lsdaa_far_model (
	input wire logic i_clk,
	input wire logic i_send,
	input wire logic [15:0] i_sample,
	output logic o_valid,
	output logic [15:0] o_data
);
	initial begin
		o_valid = 1'b0;
		o_data = 16'h0000;
	end
	// one-cycle sample, then the data lines toggle between the inverse and the last value
	always @(posedge i_clk) begin
		o_valid <= i_send;
		o_data <= i_send ? i_sample : ~o_data;
	end
endmodule

// File: tb_line_side_daa_control_registers.sv
/*
 * tb_line_side_daa_control_registers: self-checking bench for the register
 * bank and its sample path, expected results queued per output.
 * assumes: lsdaa_pkg compiled first, far side modelled by lsdaa_far_model.
 */
`timescale 1ns/1ps
module tb_line_side_daa_control_registers import lsdaa_pkg::*;;
	logic i_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic [5:0] i_addr = 6'h00;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [7:0] o_rdata;
	logic [7:0] i_dev_status = 8'h00;
	logic [7:0] i_loop_current = 8'h00;
	logic [7:0] i_line_voltage = 8'h00;
	logic i_tx_valid = 1'b0;
	logic [15:0] i_tx_data = 16'h0000;
	logic line_send = 1'b0; // ask the far side for a sample
	logic line_valid;
	logic [15:0] line_data;
	logic o_rx_valid, o_line_valid, o_off_hook, rd_seen = 1'b0;
	logic [15:0] o_rx_data, o_line_data;
	logic [1:0] o_pulse_width_mode_select;
	logic [15:0] q_rd[$], q_rx[$], q_line[$]; // expected results
	logic [7:0] r; // random value
	logic [5:0] rw_addr[5] = '{ADDR_LIF_A, ADDR_MON_RX, ADDR_RING_C, ADDR_THR_CTL, ADDR_SPARK};
	int n_mismatch = 0;
	int tests_run = 0;

	lsdaa_regs #(.W(16), .REVISION(8'h5a)) DUT (.i_clk(i_clk), .i_resetn(i_resetn),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_dev_status(i_dev_status), .i_loop_current(i_loop_current),
		.i_line_voltage(i_line_voltage), .i_tx_valid(i_tx_valid), .i_tx_data(i_tx_data),
		.i_line_valid(line_valid), .i_line_data(line_data), .o_rx_valid(o_rx_valid),
		.o_rx_data(o_rx_data), .o_line_valid(o_line_valid), .o_line_data(o_line_data),
		.o_off_hook(o_off_hook), .o_pulse_width_mode_select(o_pulse_width_mode_select));
	lsdaa_far_model FAR (.i_clk(i_clk), .i_send(line_send), .i_sample(i_tx_data),
		.o_valid(line_valid), .o_data(line_data));

	initial begin
		forever #4 i_clk = ~i_clk;
	end

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish;
		$display("counts: %0d compared, %0d wrong", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// one bus and sample cycle; every strobe set each time, none lowered twice
	task automatic drive(input logic w, rr, t, l, input logic [5:0] a, input logic [15:0] d);
		i_wr <= w;
		i_rd <= rr;
		i_tx_valid <= t;
		line_send <= l;
		i_addr <= a;
		i_wdata <= d[7:0];
		i_tx_data <= d;
		@(posedge i_clk);
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		drive(1, 0, 0, 0, a, {8'h00, d});
	endtask
	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		q_rd.push_back({8'h00, e});
		drive(0, 1, 0, 0, a, 16'h0000);
	endtask
	task automatic nop(input int n);
		repeat (n) drive(0, 0, 0, 0, 6'h00, 16'h0000);
	endtask

	// read data is checked only in the cycle after the strobe
	always @(posedge i_clk) rd_seen <= i_rd;
	always @(negedge i_clk) begin
		if (rd_seen) check({8'h00, o_rdata}, q_rd.size() ? q_rd.pop_front() : 16'hxxxx);
		if (o_rx_valid) check(o_rx_data, q_rx.size() ? q_rx.pop_front() : 16'hxxxx);
		if (o_line_valid) check(o_line_data, q_line.size() ? q_line.pop_front() : 16'hxxxx);
	end

	// bounded run, a hang counts as a mismatch
	initial begin
		repeat (3000) @(posedge i_clk);
		n_mismatch++;
		tally_and_finish;
	end

	initial begin
		void'($urandom(32'hfeb5));
		repeat (10) @(posedge i_clk);
		i_resetn <= 1'b1;
		@(posedge i_clk);
		// plain registers, reserved and unmapped places, status, revision
		r = 8'($urandom);
		wr(ADDR_PATH_GAIN, r);
		rd(ADDR_PATH_GAIN, r);
		foreach (rw_addr[k]) begin
			r = 8'($urandom);
			wr(rw_addr[k], r);
			rd(rw_addr[k], r);
		end
		wr(ADDR_RSVD_14, 8'hff);
		rd(ADDR_RSVD_14, 8'h00);
		rd(6'h20, 8'h00);
		rd(ADDR_DEV_REV, 8'h5a);
		r = 8'($urandom);
		i_loop_current <= r;
		i_dev_status <= ~r;
		i_line_voltage <= r ^ 8'h3c;
		nop(5);
		rd(ADDR_LOOP_I, r);
		rd(ADDR_DEV_STATUS, ~r);
		rd(ADDR_LINE_V, r ^ 8'h3c);
		nop(2);
		$display("test registers done");
		// reserved control bits and every pwm mode
		wr(ADDR_HOOK_CTRL, 8'h01);
		wr(ADDR_MAIN_CTRL, 8'h7f);
		rd(ADDR_MAIN_CTRL, 8'h32);
		for (int m = 0; m < 4; m++) begin
			wr(ADDR_MAIN_CTRL, {2'b00, m[1:0], 4'h0});
			nop(2);
			check({14'h0000, o_pulse_width_mode_select}, m[15:0]);
		end
		wr(ADDR_HOOK_CTRL, 8'h00);
		$display("test main control done");
		// hook state
		wr(ADDR_HOOK_CTRL, 8'h01);
		nop(2);
		check({15'h0000, o_off_hook}, 16'h0001);
		rd(ADDR_HOOK_CTRL, 8'h01);
		wr(ADDR_HOOK_CTRL, 8'h00);
		nop(2);
		check({15'h0000, o_off_hook}, 16'h0000);
		$display("test hook done");
		// sample path: attenuation 2, gain 3, then loopback, then mute
		wr(ADDR_PATH_GAIN, 8'h23);
		r = 8'($urandom);
		q_line.push_back({8'h00, r} >> 2);
		drive(0, 0, 1, 0, 6'h00, {8'h00, r});
		nop(3);
		q_rx.push_back(16'h8421 >> 1);
		drive(0, 0, 0, 1, 6'h00, 16'h8421);
		nop(3);
		wr(ADDR_HOOK_CTRL, 8'h01);
		wr(ADDR_MAIN_CTRL, 8'h02);
		nop(1);
		q_rx.push_back((16'hf0f0 >> 2) >> 1);
		drive(0, 0, 1, 0, 6'h00, 16'hf0f0);
		nop(3);
		wr(ADDR_MAIN_CTRL, 8'h00);
		wr(ADDR_PATH_GAIN, 8'ha3);
		nop(1);
		q_line.push_back(16'h0000);
		drive(0, 0, 1, 0, 6'h00, 16'hffff);
		nop(3);
		wr(ADDR_PATH_GAIN, 8'h2b);
		q_rx.push_back(16'h0000);
		drive(0, 0, 0, 1, 6'h00, 16'h5a5a);
		nop(3);
		$display("test sample path done");
		// soft reset clears gain, control and hook registers and itself
		wr(ADDR_PATH_GAIN, 8'h55);
		wr(ADDR_MAIN_CTRL, 8'h32);
		wr(ADDR_MAIN_CTRL, 8'hb2);
		wr(ADDR_PATH_GAIN, 8'h77);
		nop(2);
		rd(ADDR_PATH_GAIN, 8'h00);
		rd(ADDR_MAIN_CTRL, 8'h00);
		rd(ADDR_HOOK_CTRL, 8'h00);
		nop(2);
		check({15'h0000, o_off_hook}, 16'h0000);
		check({14'h0000, o_pulse_width_mode_select}, 16'h0000);
		check(16'(q_rd.size() + q_rx.size() + q_line.size()), 16'h0000);
		$display("test soft reset done");
		// hardware reset in mid-run: pins drop, registers return
		wr(ADDR_HOOK_CTRL, 8'h01);
		wr(ADDR_PATH_GAIN, 8'h3c);
		nop(2);
		i_resetn <= 1'b0;
		nop(2);
		check({15'h0000, o_off_hook}, 16'h0000);
		i_resetn <= 1'b1;
		nop(1);
		rd(ADDR_PATH_GAIN, 8'h00);
		rd(ADDR_HOOK_CTRL, 8'h00);
		nop(2);
		$display("test hardware reset done");
		tally_and_finish;
	end
endmodule
